/* File: logic/gdfp_pkg.sv */
package gdfp_pkg;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int STRETCH_US = 64;
  localparam int STRETCH_CYC = (STRETCH_US * (CLK_HZ / 1_000_000));
  localparam int SHUTDOWN_US = 10;
  localparam int SHUTDOWN_CYC = (SHUTDOWN_US * (CLK_HZ / 1_000_000));
  localparam int CNT_W = 13;

  // ------------------------------------------------------------
  // register map (byte offsets, 32-bit words)
  // ------------------------------------------------------------
  localparam logic [3:0] CTRL_ADDR = 4'h0;
  localparam logic [3:0] STAT_ADDR = 4'h4;
  localparam logic [3:0] CMD_ADDR = 4'h8;

  // control field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_OFFTIME_BIT = 2;
  localparam int CTRL_WSEL_LSB = 3;
  localparam int CTRL_THR_LSB = 5;
  localparam int CMD_RESET_BIT = 0;

  // status field positions
  localparam int STAT_OC_LSB = 0;
  localparam int STAT_PUV_BIT = 6;
  localparam int STAT_GUV_BIT = 7;
  localparam int STAT_GOV_BIT = 8;
  localparam int STAT_TW_BIT = 9;
  localparam int STAT_TSD_BIT = 10;

  localparam logic [4:0] THR_RESET = 5'h00;

  typedef enum logic [1:0] {
    GDFP_OC_LIMIT = 2'b00,
    GDFP_OC_LATCH = 2'b01,
    GDFP_OC_REPORT = 2'b10,
    GDFP_OC_OFF = 2'b11
  } gdfp_overcurrent_mode_field_e;

  typedef enum logic [1:0] {
    GDFP_W_BOTH = 2'b00,
    GDFP_W_TEMP = 2'b01,
    GDFP_W_OC = 2'b10,
    GDFP_W_RSV = 2'b11
  } gdfp_wsel_e;

  typedef struct packed {
    logic [4:0] threshold;
    gdfp_wsel_e warn_sel;
    logic off_time;
    gdfp_overcurrent_mode_field_e mode;
  } gdfp_ctrl_s;

  localparam gdfp_ctrl_s CTRL_RESET = '{THR_RESET, GDFP_W_BOTH, 1'b0, GDFP_OC_LIMIT};

  typedef struct packed {
    logic power_uv;
    logic gate_uv;
    logic gate_ov;
    logic temp_warn;
    logic temp_sd;
  } gdfp_supply_s;

endpackage

/* File: logic/gdfp_core.sv */
`timescale 1ns/1ps
module gdfp_core
  import gdfp_pkg::*;
#(
  parameter int STRETCH = STRETCH_CYC,
  parameter int SHUTDOWN = SHUTDOWN_CYC
) (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic [3:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  input wire logic gate_enable_in,
  input wire logic [5:0] pwm_in,
  input wire logic [5:0] oc_detect_in,
  input wire gdfp_supply_s supply_in,
  input wire logic chip_select_n_in,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_oe_out,
  output logic [5:0] gate_out,
  output logic [4:0] oc_threshold_out,
  output logic charge_pump_on_out,
  output logic blocks_on_out,
  output logic warning_out_n,
  output logic warning_oe_out,
  output logic fault_out_n,
  output logic fault_oe_out
);

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  gdfp_ctrl_s ctrl_reg;
  logic [10:0] status_reg;
  logic [5:0] pwm_prev_reg;
  logic [5:0] tripped_reg;
  logic [5:0] oc_seen_reg;
  logic [CNT_W-1:0] off_cnt_reg;
  logic [CNT_W-1:0] warn_cnt_reg;
  logic warn_hold_reg;
  logic [CNT_W-1:0] low_cnt_reg;
  logic en_prev_reg;
  logic gate_ov_latch_reg;
  logic temp_sd_latch_reg;
  logic driver_on_reg;
  logic blocks_on_reg;
  logic [2:0] phase_off_reg;
  logic soft_reset;
  logic en_rise;
  logic en_fall;
  logic [5:0] oc_act;
  logic [5:0] pwm_rise;
  logic [5:0] pwm_edge;
  logic long_low;

  assign soft_reset = wr_in && addr_in == CMD_ADDR && wdata_in[CMD_RESET_BIT];
  assign en_rise = gate_enable_in && !en_prev_reg;
  assign en_fall = !gate_enable_in && en_prev_reg;
  assign pwm_rise = pwm_in & ~pwm_prev_reg;
  assign pwm_edge = pwm_in ^ pwm_prev_reg;
  assign long_low = low_cnt_reg >= CNT_W'(SHUTDOWN);
  // disable mode masks all detections at the source
  assign oc_act = (ctrl_reg.mode == GDFP_OC_OFF) ? 6'h00 : oc_detect_in;

  // ------------------------------------------------------------
  // register bus
  // ------------------------------------------------------------
  // control is written by software; a gate-enable low does not clear it
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      ctrl_reg <= CTRL_RESET;
    end else if (wr_in && addr_in == CTRL_ADDR) begin
      ctrl_reg <= gdfp_ctrl_s'(wdata_in[9:0]);
    end
  end

  // read data stands one cycle after the strobe, unmapped reads zero
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rdata_out <= 32'h0000_0000;
    end else if (rd_in) begin
      unique case (addr_in)
        CTRL_ADDR: rdata_out <= {22'h000000, ctrl_reg};
        STAT_ADDR: rdata_out <= {21'h000000, status_reg};
        default: rdata_out <= 32'h0000_0000;
      endcase
    end else begin
      rdata_out <= 32'h0000_0000;
    end
  end

  // ------------------------------------------------------------
  // status: sticky, new events win over clearing
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      status_reg <= 11'h000;
    end else begin
      logic [10:0] ev;
      // a latch that is being cleared this cycle must not re-mark the status
      ev = {(temp_sd_latch_reg && !(en_rise || soft_reset)) | supply_in.temp_sd,
            supply_in.temp_warn,
            (gate_ov_latch_reg && !(en_rise && long_low)) | supply_in.gate_ov,
            supply_in.gate_uv, supply_in.power_uv, oc_act};
      if (en_rise || soft_reset) begin
        status_reg <= ev;
      end else begin
        status_reg <= status_reg | ev;
      end
    end
  end

  // ------------------------------------------------------------
  // gate enable: quick toggle versus full shutdown
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      en_prev_reg <= 1'b0;
      low_cnt_reg <= '0;
      blocks_on_reg <= 1'b0;
      driver_on_reg <= 1'b0;
    end else begin
      en_prev_reg <= gate_enable_in;
      if (gate_enable_in) begin
        low_cnt_reg <= '0;
        blocks_on_reg <= 1'b1;
        driver_on_reg <= 1'b1;
      end else begin
        driver_on_reg <= 1'b0;
        if (!long_low) begin
          low_cnt_reg <= low_cnt_reg + 1'b1;
        end else begin
          blocks_on_reg <= 1'b0;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // latched faults
  // ------------------------------------------------------------
  // overvoltage survives quick toggles and command; a fault still present re-latches
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      gate_ov_latch_reg <= 1'b0;
      temp_sd_latch_reg <= 1'b0;
    end else begin
      if (supply_in.gate_ov) begin
        gate_ov_latch_reg <= 1'b1;
      end else if (en_rise && long_low) begin
        gate_ov_latch_reg <= 1'b0;
      end
      if (supply_in.temp_sd) begin
        temp_sd_latch_reg <= 1'b1;
      end else if (en_rise || soft_reset) begin
        temp_sd_latch_reg <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // overcurrent limiting
  // ------------------------------------------------------------
  // one shared down-counter, reloaded by every new trip
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      pwm_prev_reg <= 6'h00;
      tripped_reg <= 6'h00;
      off_cnt_reg <= '0;
    end else begin
      pwm_prev_reg <= pwm_in;
      if (ctrl_reg.mode != GDFP_OC_LIMIT || !driver_on_reg || soft_reset) begin
        tripped_reg <= 6'h00;
        off_cnt_reg <= '0;
      end else if (!ctrl_reg.off_time) begin
        // cycle control: held off until the PWM input rises again
        tripped_reg <= (tripped_reg & ~pwm_rise) | (oc_act & pwm_in);
        off_cnt_reg <= '0;
      end else begin
        if ((oc_act & pwm_in) != 6'h00) begin
          off_cnt_reg <= CNT_W'(STRETCH);
        end else if (off_cnt_reg != '0) begin
          off_cnt_reg <= off_cnt_reg - 1'b1;
        end
        if (off_cnt_reg == CNT_W'(1) && (oc_act & pwm_in) == 6'h00) begin
          tripped_reg <= 6'h00;
        end else begin
          tripped_reg <= (tripped_reg & ~pwm_edge) | (oc_act & pwm_in);
        end
      end
    end
  end

  // latch mode: any trip takes its whole phase off until reset
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      phase_off_reg <= 3'h0;
    end else if (ctrl_reg.mode != GDFP_OC_LATCH) begin
      phase_off_reg <= 3'h0;
    end else begin
      // a trip in the same cycle as a reset wins, so a live fault stays latched
      for (int p = 0; p < 3; p++) begin
        if (oc_act[2*p] || oc_act[2*p+1]) begin
          phase_off_reg[p] <= 1'b1;
        end else if (en_rise || soft_reset) begin
          phase_off_reg[p] <= 1'b0;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // gate outputs
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      gate_out <= 6'h00;
    end else if (!driver_on_reg || supply_in.power_uv || supply_in.gate_uv
                 || gate_ov_latch_reg || temp_sd_latch_reg) begin
      gate_out <= 6'h00;
    end else begin
      logic [5:0] g;
      g = pwm_in & ~tripped_reg & ~oc_act;
      if (ctrl_reg.mode == GDFP_OC_REPORT || ctrl_reg.mode == GDFP_OC_OFF) begin
        g = pwm_in;
      end
      for (int p = 0; p < 3; p++) begin
        if (phase_off_reg[p]) begin
          g[2*p+:2] = 2'b00;
        end
      end
      gate_out <= g;
    end
  end

  // ------------------------------------------------------------
  // warning stretch
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      warn_cnt_reg <= '0;
      oc_seen_reg <= 6'h00;
      warn_hold_reg <= 1'b0;
    end else if (oc_act != 6'h00) begin
      warn_cnt_reg <= CNT_W'(STRETCH);
      oc_seen_reg <= oc_seen_reg | oc_act;
      warn_hold_reg <= 1'b1;
    end else if (warn_hold_reg) begin
      // in limit mode the pulse ends early once every tripped FET's cycle ended
      if (warn_cnt_reg == CNT_W'(1) || (ctrl_reg.mode == GDFP_OC_LIMIT
          && (oc_seen_reg & pwm_in) == 6'h00)) begin
        warn_hold_reg <= 1'b0;
        oc_seen_reg <= 6'h00;
        warn_cnt_reg <= '0;
      end else begin
        warn_cnt_reg <= warn_cnt_reg - 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // open-drain pins and serial output
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      warning_oe_out <= 1'b0;
      fault_oe_out <= 1'b1;
      serial_data_oe_out <= 1'b0;
      serial_data_out <= 1'b0;
      charge_pump_on_out <= 1'b0;
      blocks_on_out <= 1'b0;
      oc_threshold_out <= THR_RESET;
      warning_out_n <= 1'b0;
      fault_out_n <= 1'b0;
    end else begin
      // open-drain pins only ever pull low; the enables carry the state
      warning_out_n <= 1'b0;
      fault_out_n <= 1'b0;
      unique case (ctrl_reg.warn_sel)
        GDFP_W_TEMP: warning_oe_out <= supply_in.temp_warn;
        GDFP_W_OC: warning_oe_out <= warn_hold_reg;
        default: warning_oe_out <= supply_in.temp_warn | warn_hold_reg;
      endcase
      // fault held low until the driver is up, then shows any shutdown
      fault_oe_out <= !driver_on_reg || supply_in.power_uv || supply_in.gate_uv
                      || gate_ov_latch_reg || temp_sd_latch_reg || phase_off_reg != 3'h0;
      serial_data_oe_out <= !chip_select_n_in;
      serial_data_out <= serial_data_in & !chip_select_n_in;
      charge_pump_on_out <= blocks_on_reg && !gate_ov_latch_reg && !temp_sd_latch_reg;
      blocks_on_out <= blocks_on_reg;
      oc_threshold_out <= ctrl_reg.threshold;
    end
  end

endmodule

/* File: tb/gdfp_mcu_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// controller model: pwm and serial select
// ----------------------------------------
module gdfp_mcu_model (
  input wire logic sys_clk_in,
  input wire logic gate_enable_in,
  input wire logic [5:0] pwm_req_in,
  input wire logic frame_req_in,
  output logic [5:0] pwm_out = 6'h00,
  output logic chip_select_n_out = 1'b1,
  output logic serial_data_out = 1'b0
);
  // pwm edges land one cycle after the request, like a timer compare
  always_ff @(posedge sys_clk_in) begin
    pwm_out <= pwm_req_in;
  end
  // no frame is opened while the driver sleeps
  always_ff @(posedge sys_clk_in) begin
    chip_select_n_out <= !(frame_req_in && gate_enable_in);
  end
  // data line keeps toggling so a stale level never passes for data
  always_ff @(posedge sys_clk_in) begin
    serial_data_out <= !serial_data_out;
  end
endmodule

/* File: tb/gdfp_core_asserts.sv */
`timescale 1ns/1ps
// ----------------------------------------
// protection checker
// ----------------------------------------
module gdfp_core_asserts
  import gdfp_pkg::*;
#(
  parameter int STRETCH = STRETCH_CYC,
  parameter int SHUTDOWN = SHUTDOWN_CYC
) (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic [3:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic gate_enable_in,
  input wire gdfp_supply_s supply_in,
  input wire logic chip_select_n_in,
  input wire logic serial_data_oe_out,
  input wire logic [5:0] gate_out,
  input wire logic [4:0] oc_threshold_out,
  input wire logic charge_pump_on_out,
  input wire logic blocks_on_out,
  input wire logic warning_oe_out,
  input wire logic fault_oe_out
);
  logic [1:0] mode_reg;
  logic [4:0] thr_reg;
  int low_cnt_reg;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  // shadow of the control word, so mode checks need no internal probe
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      mode_reg <= 2'h0;
      thr_reg <= 5'h00;
    end else if (wr_in && addr_in == CTRL_ADDR) begin
      mode_reg <= wdata_in[1:0];
      thr_reg <= wdata_in[CTRL_THR_LSB +: 5];
    end
  end
  // cycles the enable pin has been low, saturating to stay small
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      low_cnt_reg <= 0;
    end else if (gate_enable_in) begin
      low_cnt_reg <= 0;
    end else if (low_cnt_reg < SHUTDOWN + 8) begin
      low_cnt_reg <= low_cnt_reg + 1;
    end
  end
  chk_sdo_release: assert property (chip_select_n_in |=> !serial_data_oe_out)
    else $error("serial output driven while deselected");
  chk_uv_gates_low: assert property ((supply_in.power_uv || supply_in.gate_uv) |=>
    (gate_out == 6'h00)) else $error("gates driven during undervoltage");
  chk_enable_gates_off: assert property (!gate_enable_in |-> ##2 (gate_out == 6'h00))
    else $error("gates driven with enable low");
  chk_blocks_shut_down: assert property ((low_cnt_reg > SHUTDOWN + 3) |->
    (!blocks_on_out && !charge_pump_on_out)) else $error("blocks still on after delay");
  chk_ov_latch_off: assert property (supply_in.gate_ov |-> ##3
    (gate_out == 6'h00 && !charge_pump_on_out)) else $error("overvoltage not shut down");
  chk_temp_sd_off: assert property (supply_in.temp_sd |-> ##3
    (gate_out == 6'h00 && fault_oe_out)) else $error("temperature shutdown missed");
  chk_fault_ready: assert property ($fell(fault_oe_out) |-> $past(gate_enable_in))
    else $error("fault released without enable");
  chk_warn_stretch: assert property (($rose(warning_oe_out) && !supply_in.temp_warn &&
    mode_reg == GDFP_OC_REPORT) |-> (warning_oe_out || !gate_enable_in) [*8])
    else $error("report warning not stretched");
  chk_thr_follows: assert property ((wr_in && addr_in == CTRL_ADDR) |-> ##2
    (oc_threshold_out == $past(thr_reg))) else $error("threshold code not applied");
endmodule
bind gdfp_core gdfp_core_asserts #(.STRETCH(STRETCH), .SHUTDOWN(SHUTDOWN)) u_chk (
  .sys_clk_in(sys_clk_in), .reset_in(reset_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .gate_enable_in(gate_enable_in), .supply_in(supply_in),
  .chip_select_n_in(chip_select_n_in), .serial_data_oe_out(serial_data_oe_out),
  .gate_out(gate_out), .oc_threshold_out(oc_threshold_out),
  .charge_pump_on_out(charge_pump_on_out), .blocks_on_out(blocks_on_out),
  .warning_oe_out(warning_oe_out), .fault_oe_out(fault_oe_out));

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import gdfp_pkg::*;
  localparam int ST = 20;
  localparam int SD = 5;
  logic sys_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic en = 1'b0;
  logic cs_req = 1'b0;
  logic [5:0] pwm_req = 6'h00;
  logic [5:0] oc = 6'h00;
  gdfp_supply_s sup = '0;
  logic [31:0] rdata;
  logic [5:0] pwm, gate;
  logic [4:0] thr;
  logic cs_n, sdi, sdo, sdo_oe, cp, blk, wn, w_oe, fn, f_oe, warn_pin, fault_pin;
  int n_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  // open-drain pins float high through their pull-ups
  assign warn_pin = w_oe ? wn : 1'b1;
  assign fault_pin = f_oe ? fn : 1'b1;
  gdfp_core #(.STRETCH(ST), .SHUTDOWN(SD)) DUT (
    .sys_clk_in(sys_clk_in), .reset_in(reset_in), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .gate_enable_in(en), .pwm_in(pwm),
    .oc_detect_in(oc), .supply_in(sup), .chip_select_n_in(cs_n), .serial_data_in(sdi),
    .serial_data_out(sdo), .serial_data_oe_out(sdo_oe), .gate_out(gate),
    .oc_threshold_out(thr), .charge_pump_on_out(cp), .blocks_on_out(blk),
    .warning_out_n(wn), .warning_oe_out(w_oe), .fault_out_n(fn), .fault_oe_out(f_oe));
  gdfp_mcu_model mcu (.sys_clk_in(sys_clk_in), .gate_enable_in(en), .pwm_req_in(pwm_req),
    .frame_req_in(cs_req), .pwm_out(pwm), .chip_select_n_out(cs_n), .serial_data_out(sdi));
  initial begin
    forever #10 sys_clk_in = ~sys_clk_in;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic tally_and_finish;
    if (n_errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // a hung handshake must not stall the run forever
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      tally_and_finish;
    end
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic at(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask
  // sample at the falling edge, well clear of register updates
  task automatic gate_is(input logic [5:0] e);
    @(negedge sys_clk_in);
    cmp(32'(gate), 32'(e));
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk_in);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge sys_clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk_in);
    rd <= 1'b0;
    @(negedge sys_clk_in);
    cmp(rdata & m, e);
  endtask
  task automatic trip(input logic [5:0] m);
    @(posedge sys_clk_in);
    oc <= m;
    @(posedge sys_clk_in);
    oc <= 6'h00;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_defaults;
    wr_reg(4'hC, 32'hFFFFFFFF);
    rd_reg(CTRL_ADDR, 32'hFFFFFFFF, 32'h0);
    rd_reg(4'hC, 32'hFFFFFFFF, 32'h0);
  endtask
  task automatic t_limit;
    at(1);
    pwm_req <= 6'h05;
    at(4);
    trip(6'h01);
    at(10);
    trip(6'h04);
    at(2);
    gate_is(6'h00);
    cmp(32'(warn_pin), 32'h0);
    at(ST - 6);
    gate_is(6'h00);
    cmp(32'(warn_pin), 32'h0);
    at(12);
    gate_is(6'h00);
    cmp(32'(warn_pin), 32'h1);
    at(1);
    pwm_req <= 6'h00;
    at(3);
    pwm_req <= 6'h05;
    at(3);
    gate_is(6'h05);
  endtask
  // trips on two fets share one timer; toggling one pwm frees only that fet
  task automatic t_offtime;
    wr_reg(CTRL_ADDR, 32'h4);
    at(4);
    trip(6'h01);
    at(4);
    trip(6'h04);
    at(2);
    pwm_req <= 6'h01;
    at(1);
    pwm_req <= 6'h05;
    at(4);
    gate_is(6'h04);
    at(9);
    gate_is(6'h04);
    at(8);
    gate_is(6'h05);
  endtask
  task automatic t_latch;
    wr_reg(CMD_ADDR, 32'h1);
    wr_reg(CTRL_ADDR, 32'h1);
    trip(6'h02);
    at(3);
    gate_is(6'h04);
    rd_reg(STAT_ADDR, 32'h3F, 32'h02);
    wr_reg(CMD_ADDR, 32'h1);
    at(3);
    gate_is(6'h05);
    rd_reg(STAT_ADDR, 32'h3F, 32'h00);
  endtask
  task automatic t_report;
    wr_reg(CTRL_ADDR, 32'h3E2);
    trip(6'h01);
    at(ST - 2);
    gate_is(6'h05);
    cmp(32'(warn_pin), 32'h0);
    cmp(32'(thr), 32'h1F);
    at(10);
    gate_is(6'h05);
    cmp(32'(warn_pin), 32'h1);
    rd_reg(STAT_ADDR, 32'h3F, 32'h01);
  endtask
  task automatic t_disable;
    wr_reg(CMD_ADDR, 32'h1);
    wr_reg(CTRL_ADDR, 32'h3);
    trip(6'h01);
    at(3);
    gate_is(6'h05);
    cmp(32'(warn_pin), 32'h1);
    rd_reg(STAT_ADDR, 32'h3F, 32'h00);
  endtask
  task automatic t_warn_sel;
    at(1);
    sup <= gdfp_supply_s'(5'h02);
    for (int s = 0; s < 3; s++) begin
      wr_reg(CTRL_ADDR, 32'(s << 3) | 32'h3);
      at(3);
      gate_is(6'h05);
      cmp(32'(warn_pin), 32'(s == 2));
    end
    at(1);
    sup <= '0;
    wr_reg(CTRL_ADDR, 32'hA);
    trip(6'h01);
    at(3);
    gate_is(6'h05);
    cmp(32'(warn_pin), 32'h1);
  endtask
  // undervoltage is a level, overvoltage a latch that only a long enable low clears
  task automatic t_supply;
    for (int i = 0; i < 2; i++) begin
      at(1);
      sup <= gdfp_supply_s'(5'h10 >> i);
      at(2);
      gate_is(6'h00);
      at(1);
      sup <= '0;
      at(3);
      gate_is(6'h05);
    end
    at(1);
    sup <= gdfp_supply_s'(5'h04);
    at(1);
    sup <= '0;
    at(2);
    gate_is(6'h00);
    cmp(32'(cp), 32'h0);
    at(1);
    en <= 1'b0;
    at(2);
    en <= 1'b1;
    at(4);
    gate_is(6'h00);
    wr_reg(CMD_ADDR, 32'h1);
    at(3);
    gate_is(6'h00);
    at(1);
    en <= 1'b0;
    at(SD + 5);
    gate_is(6'h00);
    cmp(32'(blk), 32'h0);
    at(1);
    en <= 1'b1;
    at(6);
    gate_is(6'h05);
    cmp(32'(cp), 32'h1);
    cmp(32'(fault_pin), 32'h1);
  endtask
  task automatic t_temp;
    at(1);
    sup <= gdfp_supply_s'(5'h01);
    at(1);
    sup <= '0;
    at(2);
    gate_is(6'h00);
    cmp(32'(fault_pin), 32'h0);
    rd_reg(CTRL_ADDR, 32'h3, 32'h2);
    rd_reg(STAT_ADDR, 32'h400, 32'h400);
    wr_reg(CMD_ADDR, 32'h1);
    at(3);
    gate_is(6'h05);
    rd_reg(STAT_ADDR, 32'h400, 32'h0);
    at(1);
    en <= 1'b0;
    at(2);
    gate_is(6'h00);
    cmp(32'(cp), 32'h1);
    cmp(32'(blk), 32'h1);
    at(1);
    en <= 1'b1;
    at(4);
    gate_is(6'h05);
  endtask
  task automatic t_serial;
    at(1);
    cs_req <= 1'b1;
    at(3);
    gate_is(6'h05);
    cmp(32'(sdo_oe), 32'h1);
    cmp(32'(sdo), 32'(!sdi));
    at(1);
    cs_req <= 1'b0;
    at(3);
    gate_is(6'h05);
    cmp(32'(sdo_oe), 32'h0);
    cmp(32'(sdo), 32'h0);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    at(8);
    reset_in <= 1'b0;
    at(2);
    gate_is(6'h00);
    cmp(32'(fault_pin), 32'h0);
    at(1);
    en <= 1'b1;
    at(5);
    gate_is(6'h00);
    cmp(32'(fault_pin), 32'h1);
    cmp(32'(cp), 32'h1);
    t_defaults;
    t_limit;
    t_offtime;
    t_latch;
    t_report;
    t_disable;
    t_warn_sel;
    t_supply;
    t_temp;
    t_serial;
    tally_and_finish;
  end
endmodule
